// >>> rtl/rpq_pkg.sv
// package for the receive preamble/sync qualifier
`default_nettype none
package rpq_pkg;
   // register offsets (byte registers on the plain port)
   localparam logic [7:0] STS1_ADDR     = 8'h03;
   localparam logic [7:0] STS2_ADDR     = 8'h04;
   localparam logic [7:0] DACC_ADDR     = 8'h30;
   localparam logic [7:0] HDR2_ADDR     = 8'h33;
   localparam logic [7:0] PLEN_ADDR     = 8'h34;
   localparam logic [7:0] PDET_ADDR     = 8'h35;
   localparam logic [7:0] SYNC3_ADDR    = 8'h36;
   localparam logic [7:0] SYNC2_ADDR    = 8'h37;
   localparam logic [7:0] SYNC1_ADDR    = 8'h38;
   localparam logic [7:0] SYNC0_ADDR    = 8'h39;
   localparam logic [7:0] IPRE_ADDR     = 8'h60;
   localparam logic [7:0] MODE_ADDR     = 8'h70;
   // reset values
   localparam logic [7:0] DACC_RST      = 8'h1D;
   localparam logic [7:0] HDR2_RST      = 8'h22;
   localparam logic [7:0] PLEN_RST      = 8'h07;
   localparam logic [7:0] PDET_RST      = 8'h20;
   localparam logic [7:0] SYNC3_RST     = 8'h2D;
   localparam logic [7:0] SYNC2_RST     = 8'hD4;
   localparam logic [7:0] SYNC1_RST     = 8'h00;
   localparam logic [7:0] SYNC0_RST     = 8'h00;
   localparam logic [7:0] IPRE_RST      = 8'h00;
   localparam logic [7:0] MODE_RST      = 8'h00;
   // field positions
   localparam int         MODE_WHITE_BIT = 0;
   localparam int         MODE_MANCH_BIT = 1;
   localparam int         MODE_MINV_BIT  = 2;
   localparam int         DACC_CRCD_BIT  = 5;
   localparam int         STS2_PDET_BIT  = 7;
   localparam int         STS2_IPRE_BIT  = 6;
   localparam int         STS1_SYNC_BIT  = 7;
   localparam int         STS1_MVIO_BIT  = 6;
   // timing in bit periods, and the pn9 seed
   localparam logic [5:0] SYNC_EXTRA    = 6'h04;
   localparam logic [5:0] NIBBLE_BITS   = 6'h04;
   localparam logic [8:0] PN9_SEED      = 9'h1FF;

   typedef enum logic [1:0] {RPQ_PRE, RPQ_SYNC, RPQ_PAY} rpq_state_t;

   typedef struct packed {
      logic whiten;
      logic manch;
      logic minv;
      logic crc_data_only;
   } rpq_cfg_t;
endpackage
`default_nettype wire

// >>> rtl/rpq_qualifier.sv
// receive preamble detect, sync search, manchester and de-whitening
//
// Our own choices: the register offsets and the address-and-strobe port.
`default_nettype none
module rpq_qualifier
(
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_rx_sym,
   input  wire logic       i_rx_sym_vld,
   input  wire logic       i_pay_end,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   output logic            o_pre_det,
   output logic            o_pre_inv,
   output logic            o_sync_ok,
   output logic            o_data,
   output logic            o_data_vld,
   output logic            o_crc_hdr,
   output logic            o_man_err
);
   logic [7:0]            r_dacc;
   logic [7:0]            r_hdr2;
   logic [7:0]            r_plen;
   logic [7:0]            r_pdet;
   logic [31:0]           r_sync;
   logic [7:0]            r_ipre;
   logic [7:0]            r_mode;
   rpq_pkg::rpq_cfg_t     cfg;
   rpq_pkg::rpq_state_t   state;
   logic                  sym_m;
   logic                  sym_s;
   logic                  vld_m;
   logic                  vld_s;
   logic                  vld_d;
   logic                  half;
   logic                  first_sym;
   logic                  bit_in;
   logic                  bit_stb;
   logic                  viol;
   logic                  last_bit;
   logic [6:0]            run;
   logic [6:0]            thr_bits;
   logic [5:0]            win_bits;
   logic [5:0]            ipre_cnt;
   logic [31:0]           shreg;
   logic [5:0]            sync_bits;
   logic [5:0]            to_cnt;
   logic                  to_run;
   logic                  sync_hit;
   logic [31:0]           sync_mask;
   logic [8:0]            pn9;
   logic                  sts_pdet;
   logic                  sts_ipre;
   logic                  sts_sync;
   logic                  sts_mvio;
   logic                  rd_sts1;
   logic                  rd_sts2;

   assign cfg.whiten        = r_mode[rpq_pkg::MODE_WHITE_BIT];
   assign cfg.manch         = r_mode[rpq_pkg::MODE_MANCH_BIT];
   assign cfg.minv          = r_mode[rpq_pkg::MODE_MINV_BIT];
   assign cfg.crc_data_only = r_dacc[rpq_pkg::DACC_CRCD_BIT];
   assign o_crc_hdr         = ~cfg.crc_data_only;

   // register port
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         r_dacc <= rpq_pkg::DACC_RST;
         r_hdr2 <= rpq_pkg::HDR2_RST;
         r_plen <= rpq_pkg::PLEN_RST;
         r_pdet <= rpq_pkg::PDET_RST;
         r_sync <= {rpq_pkg::SYNC3_RST, rpq_pkg::SYNC2_RST,
                    rpq_pkg::SYNC1_RST, rpq_pkg::SYNC0_RST};
         r_ipre <= rpq_pkg::IPRE_RST;
         r_mode <= rpq_pkg::MODE_RST;
      end
      else if (i_wr)
      begin
         unique case (i_addr)
            rpq_pkg::DACC_ADDR:  r_dacc <= i_wdata;
            rpq_pkg::HDR2_ADDR:  r_hdr2 <= i_wdata;
            rpq_pkg::PLEN_ADDR:  r_plen <= i_wdata;
            rpq_pkg::PDET_ADDR:  r_pdet <= {i_wdata[7:3], 3'h0};
            rpq_pkg::SYNC3_ADDR: r_sync[31:24] <= i_wdata;
            rpq_pkg::SYNC2_ADDR: r_sync[23:16] <= i_wdata;
            rpq_pkg::SYNC1_ADDR: r_sync[15:8]  <= i_wdata;
            rpq_pkg::SYNC0_ADDR: r_sync[7:0]   <= i_wdata;
            rpq_pkg::IPRE_ADDR:  r_ipre <= i_wdata;
            rpq_pkg::MODE_ADDR:  r_mode <= i_wdata;
            default:             ;
         endcase
      end
   end

   assign rd_sts1 = i_rd && (i_addr == rpq_pkg::STS1_ADDR);
   assign rd_sts2 = i_rd && (i_addr == rpq_pkg::STS2_ADDR);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         unique case (i_addr)
            rpq_pkg::STS1_ADDR:  o_rdata <= {sts_sync, sts_mvio, 6'h00};
            rpq_pkg::STS2_ADDR:  o_rdata <= {sts_pdet, sts_ipre, 6'h00};
            rpq_pkg::DACC_ADDR:  o_rdata <= r_dacc;
            rpq_pkg::HDR2_ADDR:  o_rdata <= r_hdr2;
            rpq_pkg::PLEN_ADDR:  o_rdata <= r_plen;
            rpq_pkg::PDET_ADDR:  o_rdata <= r_pdet;
            rpq_pkg::SYNC3_ADDR: o_rdata <= r_sync[31:24];
            rpq_pkg::SYNC2_ADDR: o_rdata <= r_sync[23:16];
            rpq_pkg::SYNC1_ADDR: o_rdata <= r_sync[15:8];
            rpq_pkg::SYNC0_ADDR: o_rdata <= r_sync[7:0];
            rpq_pkg::IPRE_ADDR:  o_rdata <= r_ipre;
            rpq_pkg::MODE_ADDR:  o_rdata <= r_mode;
            default:             o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end

   // two-flop sync of line symbols
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sym_m <= 1'b0;
         sym_s <= 1'b0;
         vld_m <= 1'b0;
         vld_s <= 1'b0;
         vld_d <= 1'b0;
      end
      else
      begin
         sym_m <= i_rx_sym;
         sym_s <= sym_m;
         vld_m <= i_rx_sym_vld;
         vld_s <= vld_m;
         vld_d <= vld_s;
      end
   end

   // manchester pairing: two symbols per bit
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         half      <= 1'b0;
         first_sym <= 1'b0;
      end
      else if (!cfg.manch)
         half <= 1'b0;
      else if (vld_s && !vld_d)
      begin
         half      <= ~half;
         first_sym <= sym_s;
      end
   end

   always_comb
   begin
      bit_stb = vld_s && !vld_d && (!cfg.manch || half);
      viol    = cfg.manch && (first_sym == sym_s);
      if (cfg.manch)
         bit_in = first_sym ^ cfg.minv;
      else
         bit_in = sym_s;
   end

   // preamble run length, alternating with zero first
   assign thr_bits = {r_pdet[7:3], 2'h0};
   assign win_bits = {2'h0, r_ipre[7:4]} * rpq_pkg::NIBBLE_BITS;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         run      <= 7'h00;
         last_bit <= 1'b1;
      end
      else if (state != rpq_pkg::RPQ_PRE)
      begin
         run      <= 7'h00;
         last_bit <= 1'b1;
      end
      else if (bit_stb)
      begin
         last_bit <= bit_in;
         if (run == 7'h00)
            run <= bit_in ? 7'h00 : 7'h01;
         else if (bit_in != last_bit && !viol)
            run <= (run == 7'h7F) ? run : run + 7'h01;
         else
            run <= bit_in ? 7'h00 : 7'h01;
      end
   end

   assign o_pre_det = (state == rpq_pkg::RPQ_PRE) && bit_stb &&
                      (thr_bits != 7'h00) && (run + 7'h01 >= thr_bits) &&
                      (bit_in != last_bit);

   // sync length and search
   assign sync_bits = {1'h0, r_hdr2[2:1], 3'h0} + 6'h08;
   always_comb
   begin
      unique case (r_hdr2[2:1])
         2'h0: sync_mask = 32'hFF000000;
         2'h1: sync_mask = 32'hFFFF0000;
         2'h2: sync_mask = 32'hFFFFFF00;
         2'h3: sync_mask = 32'hFFFFFFFF;
      endcase
   end

   // sync word left-aligned against r_sync so msb byte arrives first
   assign sync_hit = (((({shreg[30:0], bit_in} << (6'h20 - sync_bits))
                     ^ r_sync) & sync_mask) == 32'h0);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         shreg <= 32'h0;
      else if (bit_stb)
         shreg <= {shreg[30:0], bit_in};
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state  <= rpq_pkg::RPQ_PRE;
         to_cnt <= 6'h00;
         to_run <= 1'b0;
      end
      else
      begin
         unique case (state)
            rpq_pkg::RPQ_PRE:
               if (o_pre_det)
               begin
                  state  <= rpq_pkg::RPQ_SYNC;
                  to_run <= 1'b0;
                  to_cnt <= 6'h00;
               end
            rpq_pkg::RPQ_SYNC:
               if (bit_stb)
               begin
                  if (to_run && sync_hit)
                     state <= rpq_pkg::RPQ_PAY;
                  else if (!to_run && bit_in == shreg[0])
                  begin
                     to_run <= 1'b1;
                     to_cnt <= 6'h01;
                  end
                  else if (to_run && to_cnt >= sync_bits + rpq_pkg::SYNC_EXTRA)
                  begin
                     state  <= rpq_pkg::RPQ_PRE;
                     to_run <= 1'b0;
                  end
                  else if (to_run)
                     to_cnt <= to_cnt + 6'h01;
               end
            rpq_pkg::RPQ_PAY:
               if (i_pay_end)
                  state <= rpq_pkg::RPQ_PRE;
         endcase
      end
   end

   assign o_sync_ok = (state == rpq_pkg::RPQ_PAY);

   // invalid preamble window
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         ipre_cnt <= 6'h00;
      else if (state != rpq_pkg::RPQ_PRE || o_pre_det)
         ipre_cnt <= 6'h00;
      else if (bit_stb && ipre_cnt != 6'h3F)
         ipre_cnt <= ipre_cnt + 6'h01;
   end
   assign o_pre_inv = (state == rpq_pkg::RPQ_PRE) && (win_bits != 6'h00) &&
                      bit_stb && (ipre_cnt + 6'h01 == win_bits);

   // pn9 de-whitening, x9+x5+1, seeded at payload start
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         pn9 <= rpq_pkg::PN9_SEED;
      else if (state != rpq_pkg::RPQ_PAY)
         pn9 <= rpq_pkg::PN9_SEED;
      else if (bit_stb)
         pn9 <= {pn9[0] ^ pn9[5], pn9[8:1]};
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_data     <= 1'b0;
         o_data_vld <= 1'b0;
         o_man_err  <= 1'b0;
      end
      else
      begin
         o_data_vld <= bit_stb && (state == rpq_pkg::RPQ_PAY);
         o_man_err  <= bit_stb && viol;
         o_data     <= bit_in ^ (cfg.whiten & pn9[0]);
      end
   end

   // sticky status, set wins over read-clear
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sts_pdet <= 1'b0;
         sts_ipre <= 1'b0;
         sts_sync <= 1'b0;
         sts_mvio <= 1'b0;
      end
      else
      begin
         sts_pdet <= o_pre_det | (sts_pdet & ~rd_sts2);
         sts_ipre <= o_pre_inv | (sts_ipre & ~rd_sts2);
         sts_sync <= (state == rpq_pkg::RPQ_SYNC && bit_stb && to_run &&
                      sync_hit) |
                     (sts_sync & ~rd_sts1);
         sts_mvio <= (bit_stb & viol) | (sts_mvio & ~rd_sts1);
      end
   end
endmodule
`default_nettype wire

// >>> tb/rpq_qualifier_properties.sv
// port checker for the preamble/sync qualifier
`default_nettype none
module rpq_qualifier_chk
(
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic       i_rx_sym,
   input wire logic       i_rx_sym_vld,
   input wire logic       i_pay_end,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_pre_det,
   input wire logic       o_pre_inv,
   input wire logic       o_sync_ok,
   input wire logic       o_data,
   input wire logic       o_data_vld,
   input wire logic       o_crc_hdr,
   input wire logic       o_man_err
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_crc_wr;
      i_wr && i_addr == rpq_pkg::DACC_ADDR;
   endsequence
   sequence s_bit_gap;
      !o_data_vld [*2];
   endsequence
   a_rd_idle_zero:
      assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read");
   a_det_one_pulse: assert property (o_pre_det |=> !o_pre_det)
      else $error("detect pulse too long");
   a_det_in_search: assert property (o_pre_det |-> !o_sync_ok)
      else $error("detect during payload");
   a_inv_pulse_gap: assert property (o_pre_inv |=> !o_pre_inv [*3])
      else $error("invalid pulse too long");
   a_end_to_search: assert property (i_pay_end |=> !o_sync_ok)
      else $error("payload end ignored");
   a_bit_in_payload: assert property (o_data_vld |-> o_sync_ok)
      else $error("data outside payload");
   a_bit_spacing: assert property (o_data_vld |=> s_bit_gap)
      else $error("data bits too close");
   a_crc_select:
      assert property (s_crc_wr |=> o_crc_hdr == !$past(i_wdata[5]))
      else $error("crc cover not from write");
   a_crc_hold:
      assert property (!(i_wr && i_addr == rpq_pkg::DACC_ADDR)
                       |=> $stable(o_crc_hdr))
      else $error("crc cover changed alone");
   a_err_one_pulse: assert property (o_man_err |=> !o_man_err)
      else $error("coding error pulse too long");
endmodule
bind rpq_qualifier rpq_qualifier_chk u_chk
(
   .i_clk, .i_nrst, .i_rx_sym, .i_rx_sym_vld, .i_pay_end, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pre_det, .o_pre_inv, .o_sync_ok,
   .o_data, .o_data_vld, .o_crc_hdr, .o_man_err
);
`default_nettype wire

// >>> tb/rpq_tx.sv
// remote transmitter model sending preamble, sync and payload symbols
`default_nettype none
module rpq_tx
(
   input  wire logic i_clk,
   output var logic  o_sym,
   output var logic  o_vld
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       man;
   logic       inv;
   logic [8:0] pn;
   initial
   begin
      {o_sym, o_vld, man, inv} = 4'h0;
   end
   // symbol held around its strobe, inverted once released
   task automatic sym(input logic b);
      @(posedge i_clk);
      o_sym <= b;
      repeat (2) @(posedge i_clk);
      o_vld <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_vld <= 1'b0;
      o_sym <= ~b;
   endtask
   // low n bits of w, most significant first
   task automatic bits(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         if (man)
         begin
            sym(w[i] ^ inv);
            sym(~(w[i] ^ inv));
         end
         else
            sym(w[i]);
      end
   endtask
   task automatic pre(input int n, input logic ph);
      for (int i = 0; i < n; i++)
         bits({31'h0, ph ^ i[0]}, 1);
   endtask
   task automatic pay(input logic [15:0] d, input logic wht);
      pn = 9'h1FF;
      for (int i = 15; i >= 0; i--)
      begin
         bits({31'h0, d[i] ^ (wht & pn[0])}, 1);
         pn = {pn[0] ^ pn[5], pn[8:1]};
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_rx_preamble_sync_qualifier.sv
// self-checking bench for the preamble/sync qualifier
`default_nettype none
module tb_rx_preamble_sync_qualifier;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk, i_nrst, sym, vld, i_pay_end, i_wr, i_rd;
   logic [7:0]  i_addr, i_wdata, o_rdata, rv;
   logic        o_pre_det, o_pre_inv, o_sync_ok, o_data, o_data_vld;
   logic        o_crc_hdr, o_man_err;
   logic [15:0] pay;
   logic        q[$];
   int          error_cnt, cmp_count, n_det, n_inv, n_err, cyc;
   logic [15:0] rst_tbl [13] = '{16'h301D, 16'h3322, 16'h3407, 16'h3520,
      16'h362D, 16'h37D4, 16'h3800, 16'h3900, 16'h6000, 16'h7000,
      16'h0300, 16'h0400, 16'h5000};
   logic [7:0]  md [4] = '{8'h00, 8'h01, 8'h03, 8'h07};
   rpq_qualifier dut
   (
      .i_clk, .i_nrst, .i_rx_sym(sym), .i_rx_sym_vld(vld), .i_pay_end,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pre_det, .o_pre_inv,
      .o_sync_ok, .o_data, .o_data_vld, .o_crc_hdr, .o_man_err
   );
   rpq_tx tx (.i_clk, .o_sym(sym), .o_vld(vld));
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         $display("FAIL %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask
   task automatic settle();
      repeat (4) @(posedge i_clk);
      #1;
   endtask
   task automatic pe();
      @(posedge i_clk);
      i_pay_end <= 1'b1;
      @(posedge i_clk);
      i_pay_end <= 1'b0;
      settle();
   endtask
   // pulse counters, payload compare and hang guard
   always @(posedge i_clk)
   begin
      cyc++;
      n_det += int'(o_pre_det === 1'b1);
      n_inv += int'(o_pre_inv === 1'b1);
      n_err += int'(o_man_err === 1'b1);
      if (o_data_vld === 1'b1 && q.size() > 0)
         chk("payload bit", 8'(q.pop_front()), 8'(o_data));
      if (cyc == 40000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   initial
   begin
      {i_nrst, i_pay_end, i_wr, i_rd, i_addr, i_wdata} = 20'h0;
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      foreach (rst_tbl[k])
      begin
         rd(rst_tbl[k][15:8]);
         chk("reset value", rst_tbl[k][7:0], rv);
      end
      chk("crc cover", 8'h01, 8'(o_crc_hdr));
      wr(8'h50, 8'hFF);
      rd(8'h50);
      chk("unmapped", 8'h00, rv);
      wr(8'h33, 8'h23);
      rd(8'h33);
      chk("length msb", 8'h23, rv);
      wr(8'h33, 8'h22);
      wr(8'h30, 8'h3D);
      settle();
      chk("crc cover", 8'h00, 8'(o_crc_hdr));
      $display("registers done");
      wr(8'h60, 8'h20);
      tx.bits(32'hFF, 7);
      settle();
      chk("invalid early", 8'h00, 8'(n_inv));
      tx.bits(32'h2, 2);
      settle();
      chk("invalid", 8'h01, 8'(n_inv != 0));
      rd(8'h04);
      chk("invalid status", 8'h40, rv & 8'h40);
      wr(8'h60, 8'h00);
      $display("invalid preamble done");
      wr(8'h35, 8'h28);
      tx.pre(19, 1'b0);
      settle();
      chk("early detect", 8'h00, 8'(n_det));
      tx.pre(2, 1'b1);
      settle();
      chk("detect", 8'h01, 8'(n_det));
      rd(8'h04);
      chk("detect status", 8'h80, rv & 8'h80);
      rd(8'h04);
      chk("status cleared", 8'h00, rv & 8'h80);
      tx.bits(32'hFFFFFF, 24);
      tx.pre(20, 1'b0);
      settle();
      chk("detect again", 8'h02, 8'(n_det));
      $display("preamble detect done");
      wr(8'h38, 8'h5A);
      wr(8'h39, 8'h96);
      for (int k = 0; k < 4; k++)
      begin
         pe();
         wr(8'h70, md[k]);
         wr(8'h33, {5'b00100, 2'(k), 1'b0});
         tx.man = md[k][1];
         tx.inv = md[k][2];
         pay = 16'hC3A5 + 16'(k);
         tx.pre(32, 1'b0);
         tx.bits(32'h2DD45A96 >> (8 * (3 - k)), 8 * (k + 1));
         settle();
         chk("sync found", 8'h01, 8'(o_sync_ok));
         for (int i = 15; i >= 0; i--)
            q.push_back(pay[i]);
         tx.pay(pay, md[k][0]);
         settle();
         chk("bits left", 8'h00, 8'(q.size()));
         pe();
         chk("back to search", 8'h00, 8'(o_sync_ok));
      end
      $display("frames done");
      wr(8'h70, 8'h02);
      wr(8'h33, 8'h20);
      tx.man = 1'b1;
      tx.inv = 1'b0;
      tx.pre(32, 1'b0);
      tx.bits(32'h2D, 8);
      tx.sym(1'b0);
      tx.sym(1'b0);
      settle();
      chk("coding error", 8'h01, 8'(n_err));
      rd(8'h03);
      chk("status one", 8'hC0, rv & 8'hC0);
      pe();
      $display("coding error done");
      complete_run();
   end
endmodule
`default_nettype wire
